// ### pkg/icsp_link_if.sv
// Two-wire open-drain link joining host and device
`timescale 1ns/1ps
interface icsp_link_if;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic scl;
  logic sda;

  // Wired-AND with pull-up: a released line reads high
  assign scl = host_scl_oe ? host_scl_o : 1'h1;
  assign sda = (host_sda_oe ? host_sda_o : 1'h1) & (dev_sda_oe ? dev_sda_o : 1'h1);

  modport host (
    output host_scl_o,
    output host_scl_oe,
    output host_sda_o,
    output host_sda_oe,
    input scl,
    input sda
  );

  modport dev (
    output dev_sda_o,
    output dev_sda_oe,
    input scl,
    input sda
  );
endinterface : icsp_link_if

// ### pkg/icsp_pkg.sv
// Shared constants and types for the serial control port
package icsp_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Addressing and framing
  localparam logic [6:0] ICSP_DEV_ADDR = 7'h1A;
  localparam logic DIR_WRITE = 1'h0;
  localparam logic DIR_READ = 1'h1;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;
  localparam int REG_COUNT = 256;
  localparam logic [7:0] REG_RESET = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Host timing: one quarter of a bit period
  localparam int REF_PERIOD_NS = 100;
  localparam int QTR_NS = 2500;
  localparam int QTR_CYC = (QTR_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;
  localparam logic [4:0] QTR_LAST = 5'(QTR_CYC - 1);
  localparam logic [1:0] PH_LAST = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // Host byte stages within one command
  localparam logic [2:0] STG_ADDR_W = 3'h0;
  localparam logic [2:0] STG_INDEX = 3'h1;
  localparam logic [2:0] STG_WDATA = 3'h2;
  localparam logic [2:0] STG_ADDR_R = 3'h3;
  localparam logic [2:0] STG_RDATA = 3'h4;

  typedef logic [7:0] icsp_byte_t;

  typedef enum logic [2:0] {
    DS_IDLE = 3'h0,
    DS_ADDR = 3'h1,
    DS_INDEX = 3'h3,
    DS_WDATA = 3'h2,
    DS_READ = 3'h6
  } icsp_dev_state_e;

  typedef enum logic [2:0] {
    HS_IDLE = 3'h0,
    HS_START = 3'h1,
    HS_BYTE = 3'h3,
    HS_RSTART = 3'h2,
    HS_STOP = 3'h6,
    HS_DONE = 3'h7
  } icsp_host_state_e;

endpackage : icsp_pkg

// ### src/icsp_dev.sv
// Device end: control port slave with its register array
`timescale 1ns/1ps

// Functional notes
// - Answer only slave address 0011010 plus direction
// - Data changes only while clock low
// - Data falling with clock high is START
// - Data rising with clock high is STOP
// - Only the master makes START and STOP
// - Bus busy from START until STOP
// - Repeated START restarts address reception
// - Bytes are eight bits, MSB first
// - Master clocks the acknowledge pulse too
// - Transmitter releases data during acknowledge
// - Receiver pulls data low on 9th pulse
// - Addressed receiver acknowledges every byte
// - Direction bit: 0 write, 1 read
// - First written byte is register index
// - Next written byte stored to register
// - Write applied at final acknowledge rising edge
// - Master writes index before a read
module icsp_dev (
  input wire logic ref_clk,
  input wire logic sys_rst,
  icsp_link_if.dev link,
  output logic reg_wr,
  output icsp_pkg::icsp_byte_t reg_idx,
  output icsp_pkg::icsp_byte_t reg_data,
  output logic bus_busy
);
  import icsp_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Link clock domain: declarations
  icsp_dev_state_e st;
  logic [3:0] cnt;
  icsp_byte_t sh;
  icsp_byte_t rx;
  icsp_byte_t idx;
  icsp_byte_t rd_byte;
  icsp_byte_t wr_idx;
  icsp_byte_t wr_data;
  icsp_byte_t regs [0:REG_COUNT-1];
  logic start_tgl;
  logic stop_tgl;
  logic start_seen;
  logic wr_tgl;
  logic sda_drv;
  logic new_start;
  logic addr_hit;
  logic ack_edge;

  // Framing and address decode
  assign new_start = start_tgl ^ start_seen;
  assign addr_hit = (rx[7:1] == ICSP_DEV_ADDR);
  assign ack_edge = (cnt == ACK_SLOT) && !new_start;

  // Open-drain pin: only ever pulls low
  assign link.dev_sda_o = 1'h0;
  assign link.dev_sda_oe = sda_drv;

  ////////////////////////////////////////////////////////////////////////////
  // START and STOP catchers, clocked by the data line itself.
  // The link clock stands still around frames, so these edges
  // cannot be seen by the clock domain directly.

  // Falling data while clock high
  always_ff @(negedge link.sda or posedge sys_rst) begin
    if (sys_rst) begin
      start_tgl <= 1'h0;
    end else if (link.scl) begin
      start_tgl <= ~start_tgl;
    end
  end

  // Rising data while clock high
  always_ff @(posedge link.sda or posedge sys_rst) begin
    if (sys_rst) begin
      stop_tgl <= 1'h0;
    end else if (link.scl) begin
      stop_tgl <= ~stop_tgl;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bit counter, shifter and session state on the rising clock edge.
  // A START seen at a rising edge makes that edge the first address bit,
  // so a repeated START behaves exactly like a first one.
  always_ff @(posedge link.scl or posedge sys_rst) begin
    if (sys_rst) begin
      st <= DS_IDLE;
      cnt <= 4'h0;
      sh <= 8'h00;
      rx <= 8'h00;
      start_seen <= 1'h0;
    end else begin
      start_seen <= start_tgl;
      if (new_start) begin
        st <= DS_ADDR;
        cnt <= 4'h1;
        sh <= {7'h00, link.sda};
      end else if (st != DS_IDLE) begin
        if (cnt < ACK_SLOT) begin
          cnt <= cnt + 4'h1;
          sh <= {sh[6:0], link.sda};
          if (cnt == LAST_DATA_BIT) begin
            rx <= {sh[6:0], link.sda};
          end
        end else begin
          cnt <= 4'h0;
          case (st)
            DS_ADDR: begin
              if (!addr_hit) begin
                st <= DS_IDLE;
              end else if (rx[0] == DIR_READ) begin
                st <= DS_READ;
              end else begin
                st <= DS_INDEX;
              end
            end
            DS_INDEX: st <= DS_WDATA;
            DS_WDATA: st <= DS_WDATA;
            // Master acknowledge keeps reading, release ends it
            DS_READ: st <= link.sda ? DS_IDLE : DS_READ;
            default: st <= DS_IDLE;
          endcase
        end
      end
    end
  end

  // Register index taken at the index byte's acknowledge
  always_ff @(posedge link.scl or posedge sys_rst) begin
    if (sys_rst) begin
      idx <= 8'h00;
    end else if (st == DS_INDEX && ack_edge) begin
      idx <= rx;
    end
  end

  // Register array, written at the data acknowledge rising edge
  always_ff @(posedge link.scl or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        regs[i] <= REG_RESET;
      end
    end else if (st == DS_WDATA && ack_edge) begin
      regs[idx] <= rx;
    end
  end

  // Copy of the last write for the system side
  always_ff @(posedge link.scl or posedge sys_rst) begin
    if (sys_rst) begin
      wr_idx <= 8'h00;
      wr_data <= 8'h00;
      wr_tgl <= 1'h0;
    end else if (st == DS_WDATA && ack_edge) begin
      wr_idx <= idx;
      wr_data <= rx;
      wr_tgl <= ~wr_tgl;
    end
  end

  // Read byte fetched on entering a read and after each master acknowledge
  always_ff @(posedge link.scl or posedge sys_rst) begin
    if (sys_rst) begin
      rd_byte <= 8'h00;
    end else if (ack_edge) begin
      if ((st == DS_ADDR && addr_hit && rx[0] == DIR_READ) || (st == DS_READ && !link.sda)) begin
        rd_byte <= regs[idx];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data line drive, changed only on the falling clock edge
  always_ff @(negedge link.scl or posedge sys_rst) begin
    if (sys_rst) begin
      sda_drv <= 1'h0;
    end else begin
      case (st)
        DS_ADDR: sda_drv <= (cnt == ACK_SLOT) && addr_hit;
        DS_INDEX: sda_drv <= (cnt == ACK_SLOT);
        DS_WDATA: sda_drv <= (cnt == ACK_SLOT);
        // Bits MSB first, then release for the master's answer
        DS_READ: sda_drv <= (cnt < ACK_SLOT) && !rd_byte[~cnt[2:0]];
        default: sda_drv <= 1'h0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // System clock domain: toggles cross through two flops each
  logic wr_s;
  logic start_s;
  logic stop_s;
  logic wr_prev;
  logic start_prev;
  logic stop_prev;

  icsp_sync u_sync_wr (
    .clk(ref_clk),
    .rst(sys_rst),
    .d(wr_tgl),
    .q(wr_s)
  );

  icsp_sync u_sync_start (
    .clk(ref_clk),
    .rst(sys_rst),
    .d(start_tgl),
    .q(start_s)
  );

  icsp_sync u_sync_stop (
    .clk(ref_clk),
    .rst(sys_rst),
    .d(stop_tgl),
    .q(stop_s)
  );

  // Write event: one-cycle strobe with index and value
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      wr_prev <= 1'h0;
      reg_wr <= 1'h0;
      reg_idx <= 8'h00;
      reg_data <= 8'h00;
    end else begin
      wr_prev <= wr_s;
      reg_wr <= wr_s ^ wr_prev;
      if (wr_s ^ wr_prev) begin
        reg_idx <= wr_idx; // Held stable long before the toggle arrives
        reg_data <= wr_data;
      end
    end
  end

  // Bus occupancy: set by START, cleared by STOP
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      start_prev <= 1'h0;
      stop_prev <= 1'h0;
      bus_busy <= 1'h0;
    end else begin
      start_prev <= start_s;
      stop_prev <= stop_s;
      if (start_s ^ start_prev) begin
        bus_busy <= 1'h1;
      end else if (stop_s ^ stop_prev) begin
        bus_busy <= 1'h0;
      end
    end
  end
endmodule : icsp_dev

// ### src/icsp_host.sv
// Host end: bus master issuing register writes and reads
`timescale 1ns/1ps
module icsp_host (
  input wire logic ref_clk,
  input wire logic sys_rst,
  icsp_link_if.host link,
  input wire logic cmd_valid,
  input wire logic cmd_read,
  input wire icsp_pkg::icsp_byte_t cmd_idx,
  input wire icsp_pkg::icsp_byte_t cmd_data,
  output logic cmd_ready,
  output logic rsp_valid,
  output icsp_pkg::icsp_byte_t rsp_data,
  output logic rsp_nack
);
  import icsp_pkg::*;

  icsp_host_state_e st;
  logic [4:0] qcnt;
  logic [1:0] ph;
  logic [3:0] bitn;
  logic [2:0] stg;
  logic rd;
  icsp_byte_t idx;
  icsp_byte_t dat;
  icsp_byte_t rxb;
  icsp_byte_t txb;
  logic nack;
  logic tick;
  logic sda_s;
  logic scl_low;
  logic sda_low;
  logic receiving;
  logic take;

  assign tick = (qcnt == QTR_LAST);
  assign receiving = (stg == STG_RDATA);
  assign take = (st == HS_IDLE) && cmd_valid && cmd_ready;

  // Open-drain pins: pull low or release
  assign link.host_scl_o = 1'h0;
  assign link.host_scl_oe = scl_low;
  assign link.host_sda_o = 1'h0;
  assign link.host_sda_oe = sda_low;

  // Data line sampled through two flops
  icsp_sync u_sync_sda (
    .clk(ref_clk),
    .rst(sys_rst),
    .d(link.sda),
    .q(sda_s)
  );

  // Byte to send in each stage
  always_comb begin
    case (stg)
      STG_ADDR_W: txb = {ICSP_DEV_ADDR, DIR_WRITE};
      STG_INDEX: txb = idx;
      STG_WDATA: txb = dat;
      STG_ADDR_R: txb = {ICSP_DEV_ADDR, DIR_READ};
      default: txb = 8'hFF;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Quarter-bit divider and phase
  always_ff @(posedge ref_clk) begin
    if (sys_rst || st == HS_IDLE) begin
      qcnt <= 5'h00;
      ph <= 2'h0;
    end else if (tick) begin
      qcnt <= 5'h00;
      ph <= ph + 2'h1;
    end else begin
      qcnt <= qcnt + 5'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command sequencer
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      st <= HS_IDLE;
      bitn <= 4'h0;
      stg <= STG_ADDR_W;
      rd <= 1'h0;
      idx <= 8'h00;
      dat <= 8'h00;
      rxb <= 8'h00;
      nack <= 1'h0;
    end else begin
      case (st)
        HS_IDLE: begin
          if (take) begin
            st <= HS_START;
            rd <= cmd_read;
            idx <= cmd_idx;
            dat <= cmd_data;
            stg <= STG_ADDR_W;
            bitn <= 4'h0;
            nack <= 1'h0;
          end
        end
        HS_START, HS_RSTART: begin
          if (tick && ph == PH_LAST) begin
            st <= HS_BYTE;
            bitn <= 4'h0;
          end
        end
        HS_BYTE: begin
          if (tick && ph == 2'h2) begin
            if (bitn < ACK_SLOT && receiving) begin
              rxb <= {rxb[6:0], sda_s};
            end else if (bitn == ACK_SLOT && !receiving && sda_s) begin
              nack <= 1'h1;
            end
          end
          if (tick && ph == PH_LAST) begin
            if (bitn < ACK_SLOT) begin
              bitn <= bitn + 4'h1;
            end else begin
              bitn <= 4'h0;
              if (nack) begin
                st <= HS_STOP;
              end else begin
                case (stg)
                  STG_ADDR_W: stg <= STG_INDEX;
                  STG_INDEX: begin
                    if (rd) begin
                      stg <= STG_ADDR_R;
                      st <= HS_RSTART;
                    end else begin
                      stg <= STG_WDATA;
                    end
                  end
                  STG_ADDR_R: stg <= STG_RDATA;
                  default: st <= HS_STOP;
                endcase
              end
            end
          end
        end
        HS_STOP: begin
          if (tick && ph == PH_LAST) begin
            st <= HS_DONE;
          end
        end
        HS_DONE: st <= HS_IDLE;
        default: st <= HS_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drive per quarter: data moves only while the clock is low, except in HS_START, HS_RSTART and HS_STOP
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      scl_low <= 1'h0;
      sda_low <= 1'h0;
    end else if (tick) begin
      case (st)
        HS_START: begin
          if (ph == 2'h0) sda_low <= 1'h1;
          if (ph == PH_LAST) scl_low <= 1'h1;
        end
        HS_RSTART: begin
          if (ph == 2'h0) sda_low <= 1'h0;
          if (ph == 2'h1) scl_low <= 1'h0;
          if (ph == 2'h2) sda_low <= 1'h1;
          if (ph == PH_LAST) scl_low <= 1'h1;
        end
        HS_BYTE: begin
          // Release for the slave ack; NACK after the single read byte
          if (ph == 2'h0) sda_low <= (bitn < ACK_SLOT) && !receiving && !txb[~bitn[2:0]];
          if (ph == 2'h1) scl_low <= 1'h0;
          if (ph == PH_LAST) scl_low <= 1'h1;
        end
        HS_STOP: begin
          if (ph == 2'h0) sda_low <= 1'h1;
          if (ph == 2'h1) scl_low <= 1'h0;
          if (ph == 2'h2) sda_low <= 1'h0;
        end
        default: begin
          scl_low <= 1'h0;
          sda_low <= 1'h0;
        end
      endcase
    end
  end

  // Command handshake and response
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cmd_ready <= 1'h0;
      rsp_valid <= 1'h0;
      rsp_data <= 8'h00;
      rsp_nack <= 1'h0;
    end else begin
      cmd_ready <= (st == HS_DONE) || (st == HS_IDLE && !take);
      rsp_valid <= (st == HS_DONE);
      if (st == HS_DONE) begin
        rsp_data <= rxb;
        rsp_nack <= nack;
      end
    end
  end
endmodule : icsp_host

// ### src/icsp_sync.sv
// Two-flop level synchroniser
`timescale 1ns/1ps
module icsp_sync (
  input wire logic clk,
  input wire logic rst,
  input wire logic d,
  output logic q
);
  logic meta;

  // First flop feeds only the second
  always_ff @(posedge clk) begin
    if (rst) begin
      meta <= 1'h0;
      q <= 1'h0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule : icsp_sync

// ### test/icsp_sva.sv
// Link protocol checker for the serial control port
`timescale 1ns/1ps
module icsp_sva (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic host_scl_oe,
  input wire logic host_sda_oe,
  input wire logic dev_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  import icsp_pkg::*;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  ////////////////////////////////////////////////////////////////////////////
  // Helper state
  logic scl_q;
  logic sda_q;
  logic sess;
  logic rs;
  logic [3:0] bc;
  logic [1:0] nb;
  wire logic rise = scl && !scl_q;
  wire logic strt = scl && scl_q && sda_q && !sda;
  wire logic stp = scl && scl_q && !sda_q && sda;
  wire logic rdb = rs && nb == 2'h1;

  // Previous line levels
  always_ff @(posedge ref_clk) begin
    scl_q <= sys_rst | scl;
    sda_q <= sys_rst | sda;
  end

  // Session and repeated start flags
  always_ff @(posedge ref_clk) begin
    if (sys_rst || stp) begin
      sess <= 1'h0;
      rs <= 1'h0;
    end else if (strt) begin
      sess <= 1'h1;
      rs <= sess;
    end
  end

  // Bit slot and byte number since the last start
  always_ff @(posedge ref_clk) begin
    if (sys_rst || strt) begin
      bc <= 4'h0;
      nb <= 2'h0;
    end else if (rise && bc == ACK_SLOT) begin
      bc <= 4'h0;
      nb <= (nb == 2'h3) ? nb : nb + 2'h1;
    end else if (rise) begin
      bc <= bc + 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Properties
  property p_addr_bits;
    rise && nb == 2'h0 && bc < 4'h7 |-> sda == ICSP_DEV_ADDR[3'h6 - bc[2:0]];
  endproperty
  a_addr_bits: assert property (p_addr_bits) else $error("address bit wrong");
  property p_dir;
    rise && nb == 2'h0 && bc == 4'(LAST_DATA_BIT) |-> sda == rs;
  endproperty
  a_dir: assert property (p_dir) else $error("direction bit wrong");
  property p_ack_dev;
    rise && bc == ACK_SLOT && !rdb |-> dev_sda_oe && !sda;
  endproperty
  a_ack_dev: assert property (p_ack_dev) else $error("byte not acknowledged");
  property p_ack_rel;
    rise && bc == ACK_SLOT && !rdb |-> !host_sda_oe;
  endproperty
  a_ack_rel: assert property (p_ack_rel) else $error("sender held data in ack");
  property p_rd_nack;
    rise && bc == ACK_SLOT && rdb |-> !dev_sda_oe && !host_sda_oe;
  endproperty
  a_rd_nack: assert property (p_rd_nack) else $error("read ack slot driven");
  property p_rd_drive;
    rise && rdb && bc < ACK_SLOT |-> !host_sda_oe;
  endproperty
  a_rd_drive: assert property (p_rd_drive) else $error("host drove read data");
  property p_dev_chg;
    $changed(dev_sda_oe) |-> !scl;
  endproperty
  a_dev_chg: assert property (p_dev_chg) else $error("device changed data, clock high");
  property p_stable_hi;
    $rose(scl) |=> $stable(sda) [*8];
  endproperty
  a_stable_hi: assert property (p_stable_hi) else $error("data moved after clock rise");
  property p_start_host;
    $fell(sda) && scl && $past(scl) |-> $rose(host_sda_oe);
  endproperty
  a_start_host: assert property (p_start_host) else $error("start not by host");
  property p_stop_host;
    $rose(sda) && scl && $past(scl) |-> $fell(host_sda_oe);
  endproperty
  a_stop_host: assert property (p_stop_host) else $error("stop not by host");
endmodule : icsp_sva

// ### test/icsp_tb.sv
// Bench joining host and device ends, plus a hand-driven second link
`timescale 1ns/1ps
module icsp_tb;
  import icsp_pkg::*;
  localparam int DLY = 1;
  localparam int BB_QTR = 8; // Quarter of the hand-made 32 ns link clock
  logic ref_clk = 1'h0;
  logic sys_rst = 1'h0;
  logic cmd_valid = 1'h0;
  logic cmd_read = 1'h0;
  icsp_byte_t cmd_idx = 8'h00;
  icsp_byte_t cmd_data = 8'h00;
  logic cmd_ready, rsp_valid, rsp_nack, reg_wr, bus_busy, reg_wr2, bus_busy2;
  icsp_byte_t rsp_data, reg_idx, reg_data, reg_idx2, reg_data2;
  int failures = 0;
  int n_compared = 0;
  int wr_seen = 0;
  int rises = 0;
  int rise_at_wr = 0;
  icsp_link_if link ();
  icsp_link_if link2 ();

  icsp_host u_icsp_host (.ref_clk(ref_clk), .sys_rst(sys_rst), .link(link.host),
    .cmd_valid(cmd_valid), .cmd_read(cmd_read), .cmd_idx(cmd_idx), .cmd_data(cmd_data),
    .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_nack(rsp_nack));
  icsp_dev u_icsp_dev (.ref_clk(ref_clk), .sys_rst(sys_rst), .link(link.dev),
    .reg_wr(reg_wr), .reg_idx(reg_idx), .reg_data(reg_data), .bus_busy(bus_busy));
  icsp_dev u_icsp_dev_b (.ref_clk(ref_clk), .sys_rst(sys_rst), .link(link2.dev),
    .reg_wr(reg_wr2), .reg_idx(reg_idx2), .reg_data(reg_data2), .bus_busy(bus_busy2));
  icsp_sva u_icsp_sva (.ref_clk(ref_clk), .sys_rst(sys_rst), .host_scl_oe(link.host_scl_oe),
    .host_sda_oe(link.host_sda_oe), .dev_sda_oe(link.dev_sda_oe), .scl(link.scl),
    .sda(link.sda));

  ////////////////////////////////////////////////////////////////////////////
  // Clock and monitors
  always #50 ref_clk = ~ref_clk;
  always @(posedge link.scl) rises++;
  always @(negedge ref_clk) begin
    if (reg_wr === 1'h1) begin
      wr_seen++;
      rise_at_wr = rises;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic do_cmd(input logic rd, input icsp_byte_t idx, input icsp_byte_t dat,
                        output icsp_byte_t got);
    int n;
    n = 0;
    while (cmd_ready !== 1'h1 && n < 100) begin
      @(posedge ref_clk);
      #DLY;
      n++;
    end
    if (n >= 100) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, cmd_ready, 1'h1);
    end
    cmd_valid = 1'h1;
    cmd_read = rd;
    cmd_idx = idx;
    cmd_data = dat;
    @(posedge ref_clk);
    rises = 0;
    #DLY;
    cmd_valid = 1'h0;
    n = 0;
    while (rsp_valid !== 1'h1 && n < 20000) begin
      @(posedge ref_clk);
      #DLY;
      n++;
    end
    got = rsp_data;
    check({7'h00, rsp_nack}, 8'h00);
    if (n >= 20000) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, rsp_valid, 1'h1);
    end
  endtask : do_cmd

  task automatic wr(input icsp_byte_t idx, input icsp_byte_t dat);
    int w0;
    icsp_byte_t g;
    w0 = wr_seen;
    do_cmd(DIR_WRITE, idx, dat, g);
    check(8'(wr_seen - w0), 8'h01);
    check(reg_idx, idx);
    check(reg_data, dat);
    check(8'(rise_at_wr), 8'(3 * (int'(ACK_SLOT) + 1)));
  endtask : wr

  task automatic rd(input icsp_byte_t idx, input icsp_byte_t exp);
    icsp_byte_t g;
    do_cmd(DIR_READ, idx, 8'h00, g);
    check(g, exp);
  endtask : rd

  // Link clock quarter, free of the system clock's phase
  task automatic bb_q();
    #BB_QTR;
  endtask : bb_q

  // Long enough for link events to reach the system side
  task automatic bb_wait();
    #(BB_QTR * 75);
  endtask : bb_wait

  task automatic bb_start();
    link2.host_sda_oe = 1'h0;
    bb_q();
    link2.host_scl_oe = 1'h0;
    bb_q();
    link2.host_sda_oe = 1'h1;
    bb_q();
    link2.host_scl_oe = 1'h1;
    bb_q();
  endtask : bb_start

  task automatic bb_byte(input icsp_byte_t b, output logic ack);
    logic [8:0] v;
    v = {b, 1'h1};
    for (int i = 8; i >= 0; i--) begin
      link2.host_sda_oe = !v[i];
      bb_q();
      link2.host_scl_oe = 1'h0;
      bb_q();
      ack = link2.sda;
      bb_q();
      link2.host_scl_oe = 1'h1;
      bb_q();
    end
  endtask : bb_byte

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_regs();
    icsp_byte_t ix [4] = '{8'h5A, 8'h80, 8'h01, 8'hFF};
    icsp_byte_t dv [4] = '{8'hC3, 8'h01, 8'h80, 8'hFF};
    rd(8'h5A, REG_RESET);
    for (int i = 0; i < 4; i++) wr(ix[i], dv[i]);
    for (int i = 0; i < 4; i++) rd(ix[i], dv[i]);
    rd(8'h33, REG_RESET);
    $display("t_regs done");
  endtask : t_regs

  task automatic t_busy();
    fork
      wr(8'h10, 8'h3C);
      begin
        repeat (500) @(posedge ref_clk);
        #DLY;
        check({7'h00, bus_busy}, 8'h01);
      end
    join
    repeat (10) @(posedge ref_clk);
    #DLY;
    check({7'h00, bus_busy}, 8'h00);
    $display("t_busy done");
  endtask : t_busy

  task automatic t_foreign();
    logic a;
    bb_start();
    bb_wait();
    check({7'h00, bus_busy2}, 8'h01);
    bb_byte({ICSP_DEV_ADDR ^ 7'h01, DIR_WRITE}, a);
    check({7'h00, a}, 8'h01);
    bb_byte(8'h10, a);
    check({7'h00, a}, 8'h01);
    bb_start();
    bb_byte({ICSP_DEV_ADDR, DIR_WRITE}, a);
    check({7'h00, a}, 8'h00);
    bb_byte(8'h44, a);
    check({7'h00, a}, 8'h00);
    bb_byte(8'h96, a);
    check({7'h00, a}, 8'h00);
    link2.host_sda_oe = 1'h1;
    bb_q();
    link2.host_scl_oe = 1'h0;
    bb_q();
    link2.host_sda_oe = 1'h0;
    bb_q();
    bb_wait();
    check({7'h00, bus_busy2}, 8'h00);
    check(reg_idx2, 8'h44);
    check(reg_data2, 8'h96);
    $display("t_foreign done");
  endtask : t_foreign

  task automatic wrap_up();
    $display("compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : wrap_up

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence and watchdog
  initial begin
    link2.host_scl_o = 1'h0;
    link2.host_sda_o = 1'h0;
    link2.host_scl_oe = 1'h0;
    link2.host_sda_oe = 1'h0;
    // Raise reset after time zero so the link-clocked flops see its edge
    #DLY;
    sys_rst = 1'h1;
    repeat (16) @(posedge ref_clk);
    #DLY;
    sys_rst = 1'h0;
    repeat (4) @(posedge ref_clk);
    #DLY;
    t_regs();
    t_busy();
    t_foreign();
    wrap_up();
  end

  initial begin
    #6000000;
    failures++;
    $display("[FAIL] t=%0t watchdog got=%h exp=%h", $time, 1'h0, 1'h1);
    wrap_up();
  end
endmodule : icsp_tb
